// [rtl/qdis_link_if.sv]
`timescale 1ns/10ps
interface qdis_link_if;
  // open-drain drivers: out is always low, oe high pulls the line down
  logic sclOut;
  logic sclOe;
  logic sdaMstOut;
  logic sdaMstOe;
  logic sdaSlvOut;
  logic sdaSlvOe;
  // resolved wire levels with pull-ups
  logic sclLine;
  logic sdaLine;
  assign sclLine = !(sclOe && !sclOut);
  assign sdaLine = !(sdaMstOe && !sdaMstOut) && !(sdaSlvOe && !sdaSlvOut);
  modport master (output sclOut, output sclOe, output sdaMstOut, output sdaMstOe, input sclLine, input sdaLine);
  modport slave (output sdaSlvOut, output sdaSlvOe, input sclLine, input sdaLine);
endinterface

// [rtl/qdis_master.sv]
`timescale 1ns/10ps
module qdis_master
  import qdis_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // two-wire link
  qdis_link_if.master link,
  // command request
  input wire logic cmdValid,
  output logic cmdReady,
  input wire qdis_pkg::qdis_cmd_type cmdKind,
  input wire logic [7:0] cmdData,
  input wire logic cmdAck,
  // command answer
  output logic rspValid,
  output logic [7:0] rspData,
  output logic rspAck,
  output logic hsRate
);
  import qdis_pkg::*;

  qdis_mst_state_type q; // registered state
  qdis_mst_state_type d; // next state
  logic [1:0] lineSync; // synchronised scl, sda
  logic [7:0] qtrLimit; // quarter bit length for current rate
  logic tick; // one-cycle quarter enable

  ////////////////////////////////////////////////////////////////////////////
  // lines come back through two flops
  qdis_sync #(.WIDTH(2), .RST_VAL(1'b1)) u_sync (
    .sys_clk(sys_clk),
    .rst(rst),
    .asyncIn({link.sdaLine, link.sclLine}),
    .syncOut(lineSync)
  );

  ////////////////////////////////////////////////////////////////////////////
  // next-state logic
  always_comb
  begin
    d = q;
    d.rspValid = 1'b0;
    // rate follows hsRate: fast until a master code completes, then high speed until a stop
    qtrLimit = q.hsRate ? HS_QTR_CYC : FS_QTR_CYC;
    tick = (q.phase != MST_IDLE) && (q.qtrCnt == qtrLimit - 8'h01);
    if (q.phase != MST_IDLE)
    begin
      d.qtrCnt = tick ? 8'h00 : q.qtrCnt + 8'h01;
    end
    case (q.phase)
      MST_IDLE:
      begin
        if (cmdValid)
        begin
          d.cmd = cmdKind;
          d.qtr = '0;
          d.qtrCnt = '0;
          d.bitIdx = '0;
          // ninth slot: release for slave ack, or our own ack on reads
          if (cmdKind == CMD_HSCODE)
          begin
            d.tx = {HS_MASTER_CODE, 1'b1};
          end
          else if (cmdKind == CMD_READ)
          begin
            d.tx = {8'hff, !cmdAck};
          end
          else
          begin
            d.tx = {cmdData, 1'b1};
          end
          d.phase = (cmdKind == CMD_START || cmdKind == CMD_STOP) ? MST_COND : MST_BITS;
        end
      end
      MST_COND:
      begin
        if (tick)
        begin
          d.qtr = q.qtr + 2'h1;
          case (q.qtr)
            2'h0: d.sdaLow = (q.cmd == CMD_STOP);
            2'h1: d.sclLow = 1'b0;
            2'h2: d.sdaLow = (q.cmd == CMD_START);
            default:
            begin
              // start leaves the clock low; stop leaves the bus free
              d.sclLow = (q.cmd == CMD_START);
              if (q.cmd == CMD_STOP)
              begin
                d.hsRate = 1'b0;
              end
              d.phase = MST_IDLE;
              d.rspValid = 1'b1;
            end
          endcase
        end
      end
      default:
      begin
        if (tick)
        begin
          d.qtr = q.qtr + 2'h1;
          case (q.qtr)
            2'h0: d.sdaLow = !q.tx[8];
            2'h1: d.sclLow = 1'b0;
            2'h2:
            begin
              if (q.bitIdx == DATA_BITS)
              begin
                d.rspAck = !lineSync[1];
              end
              else
              begin
                d.rx = {q.rx[6:0], lineSync[1]};
              end
            end
            default:
            begin
              d.sclLow = 1'b1;
              d.tx = {q.tx[7:0], 1'b1};
              d.bitIdx = q.bitIdx + 4'h1;
              if (q.bitIdx == DATA_BITS)
              begin
                d.phase = MST_IDLE;
                d.rspValid = 1'b1;
                d.rspData = q.rx;
                if (q.cmd == CMD_HSCODE)
                begin
                  d.hsRate = 1'b1;
                end
              end
            end
          endcase
        end
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      q <= MST_RESET;
    end
    else
    begin
      q <= d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  assign link.sclOut = 1'b0;
  assign link.sclOe = q.sclLow;
  assign link.sdaMstOut = 1'b0;
  assign link.sdaMstOe = q.sdaLow;
  assign cmdReady = (q.phase == MST_IDLE);
  assign rspValid = q.rspValid;
  assign rspData = q.rspData;
  assign rspAck = q.rspAck;
  assign hsRate = q.hsRate;

endmodule

// [rtl/qdis_pkg.sv]
package qdis_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // timing
  localparam int CLK_NS = 5; // sys_clk period
  localparam int SPIKE_FS_NS = 50; // widest glitch dropped at standard/fast rate
  localparam int SPIKE_HS_NS = 10; // widest glitch dropped at high-speed rate
  // longest times round down
  localparam logic [3:0] SPIKE_FS_CYC = 4'(SPIKE_FS_NS / CLK_NS);
  localparam logic [3:0] SPIKE_HS_CYC = 4'(SPIKE_HS_NS / CLK_NS);
  localparam int FS_KBPS = 400; // fast rate
  localparam int HS_KBPS = 3400; // high-speed rate
  // quarter bit period, rounded up so the rate never exceeds the limit
  localparam logic [7:0] FS_QTR_CYC = 8'((1000000 / FS_KBPS + 4 * CLK_NS - 1) / (4 * CLK_NS));
  localparam logic [7:0] HS_QTR_CYC = 8'((1000000 / HS_KBPS + 4 * CLK_NS - 1) / (4 * CLK_NS));

  ////////////////////////////////////////////////////////////////////////////
  // addressing and framing
  localparam logic [4:0] ADDR_PREFIX = 5'h13; // fixed upper address bits 10011
  localparam logic [6:0] BCAST_ADDR = 7'h48; // broadcast address 1001000
  localparam logic [4:0] HS_CODE_PREFIX = 5'h01; // master code 00001xxx
  localparam logic [7:0] HS_MASTER_CODE = 8'h08; // code this master sends
  localparam logic [3:0] DATA_BITS = 4'h8; // bit count after a whole byte
  localparam logic [3:0] ACK_SLOT = 4'h9; // bit count in the acknowledge clock
  localparam logic [1:0] BYTE_CTRL = 2'h0; // write byte order
  localparam logic [1:0] BYTE_MSB = 2'h1;
  localparam logic [1:0] BYTE_LSB = 2'h2;

  ////////////////////////////////////////////////////////////////////////////
  // master commands
  typedef enum logic [2:0] {CMD_START, CMD_STOP, CMD_WRITE, CMD_READ, CMD_HSCODE} qdis_cmd_type;

  ////////////////////////////////////////////////////////////////////////////
  // slave state
  typedef enum logic [2:0] {SLV_IDLE, SLV_ADDR, SLV_WRITE, SLV_READ, SLV_IGNORE} qdis_slv_phase_type;
  typedef struct packed {
    qdis_slv_phase_type phase;
    logic sclF; // filtered clock line
    logic sdaF; // filtered data line
    logic [3:0] sclCnt;
    logic [3:0] sdaCnt;
    logic [3:0] bitCnt;
    logic [7:0] shift;
    logic [1:0] byteIdx;
    logic rdDir;
    logic nak;
    logic sdaLow;
    logic hsMode;
    logic strapDone;
    logic [6:0] ownAddr;
    logic addressed;
    logic [7:0] ctrl;
    logic [7:0] msb;
    logic [15:0] word;
    logic wordPend;
    logic wordStb;
  } qdis_slv_state_type;
  localparam qdis_slv_state_type SLV_RESET = '{phase: SLV_IDLE, sclF: 1'b1, sdaF: 1'b1, default: '0};

  ////////////////////////////////////////////////////////////////////////////
  // master state
  typedef enum logic [1:0] {MST_IDLE, MST_COND, MST_BITS} qdis_mst_phase_type;
  typedef struct packed {
    qdis_mst_phase_type phase;
    qdis_cmd_type cmd;
    logic [7:0] qtrCnt;
    logic [1:0] qtr;
    logic [3:0] bitIdx;
    logic [8:0] tx;
    logic [7:0] rx;
    logic sclLow;
    logic sdaLow;
    logic hsRate;
    logic rspValid;
    logic [7:0] rspData;
    logic rspAck;
  } qdis_mst_state_type;
  localparam qdis_mst_state_type MST_RESET = '{phase: MST_IDLE, cmd: CMD_START, default: '0};

endpackage

// [rtl/qdis_slave.sv]
// Behaviour
// - converter code is unsigned binary 0 to 65535
// - slave only; standard, fast, high-speed rates
// - only 7-bit addresses; no general call
// - start is data falling while clock high
// - master sends address and direction after start
// - master changes data only while clock low
// - acknowledge own address in ninth clock
// - eight data bits plus receiver acknowledge
// - stop releases bus; await start plus address
// - master code 00001xxx sent at fast rate
// - never acknowledge master code; switch to high-speed
// - after repeated start same protocol, faster
// - stop leaves high-speed mode
// - master keeps high-speed using repeated starts
// - address is 10011 plus two strapped pins
// - acknowledge every received write byte
// - apply word at ack clock fall after low byte
// - broadcast address answered for writes only
`timescale 1ns/10ps
module qdis_slave
  import qdis_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // two-wire link
  qdis_link_if.slave link,
  // address-select straps
  input wire logic addr_select_bit_low,
  input wire logic addr_select_bit_high,
  // readback word, same clock domain
  input wire logic [15:0] readWord,
  // received data
  output logic [7:0] ctrlByte,
  output logic [15:0] dataWord,
  output logic wordStrobe,
  // status
  output logic hsMode,
  output logic addressed
);
  import qdis_pkg::*;

  qdis_slv_state_type q; // registered state
  qdis_slv_state_type d; // next state
  logic [3:0] pinSync; // synchronised scl, sda and straps
  logic [3:0] spikeCyc; // glitch limit for the current rate
  logic sclRise;
  logic sclFall;
  logic startSeen;
  logic stopSeen;
  logic [7:0] nextRd; // next readback byte

  ////////////////////////////////////////////////////////////////////////////
  // every pin crosses two flops first
  qdis_sync #(.WIDTH(4), .RST_VAL(1'b1)) u_sync (
    .sys_clk(sys_clk),
    .rst(rst),
    .asyncIn({addr_select_bit_high, addr_select_bit_low, link.sdaLine, link.sclLine}),
    .syncOut(pinSync)
  );

  ////////////////////////////////////////////////////////////////////////////
  // next-state logic
  always_comb
  begin
    d = q;
    d.wordStb = 1'b0;
    nextRd = q.byteIdx[0] ? readWord[7:0] : readWord[15:8];
    // glitch filter tightens in high-speed mode
    spikeCyc = q.hsMode ? SPIKE_HS_CYC : SPIKE_FS_CYC;
    // clock filter: line must hold for the whole glitch limit, spikeCyc cycles
    if (pinSync[0] == q.sclF)
    begin
      d.sclCnt = '0;
    end
    else if (q.sclCnt + 4'h1 >= spikeCyc)
    begin
      d.sclF = pinSync[0];
      d.sclCnt = '0;
    end
    else
    begin
      d.sclCnt = q.sclCnt + 4'h1;
    end
    // data filter, same scheme
    if (pinSync[1] == q.sdaF)
    begin
      d.sdaCnt = '0;
    end
    else if (q.sdaCnt + 4'h1 >= spikeCyc)
    begin
      d.sdaF = pinSync[1];
      d.sdaCnt = '0;
    end
    else
    begin
      d.sdaCnt = q.sdaCnt + 4'h1;
    end
    // edges and bus conditions on filtered lines
    sclRise = !q.sclF && d.sclF;
    sclFall = q.sclF && !d.sclF;
    startSeen = q.sclF && d.sclF && q.sdaF && !d.sdaF;
    stopSeen = q.sclF && d.sclF && !q.sdaF && d.sdaF;
    // straps followed until the first start, then frozen; locking at release would catch the sync reset level
    if (!q.strapDone)
    begin
      d.ownAddr = {ADDR_PREFIX, pinSync[3], pinSync[2]};
      d.strapDone = startSeen;
    end
    if (startSeen)
    begin
      // drop any partial byte, listen for an address
      d.phase = SLV_ADDR;
      d.bitCnt = '0;
      d.sdaLow = 1'b0;
      d.byteIdx = BYTE_CTRL;
      d.wordPend = 1'b0;
      d.addressed = 1'b0;
    end
    else if (stopSeen)
    begin
      // release the bus, fall back to standard/fast filtering
      d.phase = SLV_IDLE;
      d.sdaLow = 1'b0;
      d.hsMode = 1'b0;
      d.addressed = 1'b0;
      d.bitCnt = '0;
    end
    else
    begin
      case (q.phase)
        SLV_ADDR, SLV_WRITE:
        begin
          if (sclRise && q.bitCnt < DATA_BITS)
          begin
            // sample on the rising edge, line is stable while high
            d.shift = {q.shift[6:0], d.sdaF};
            d.bitCnt = q.bitCnt + 4'h1;
          end
          else if (sclRise && q.bitCnt == DATA_BITS)
          begin
            d.bitCnt = ACK_SLOT;
          end
          else if (sclFall && q.bitCnt == DATA_BITS && q.phase == SLV_ADDR)
          begin
            if (q.shift[7:3] == HS_CODE_PREFIX)
            begin
              // recognised but never acknowledged
              d.hsMode = 1'b1;
              d.phase = SLV_IGNORE;
            end
            else if (q.shift[7:1] == q.ownAddr || (q.shift[7:1] == BCAST_ADDR && !q.shift[0]))
            begin
              // 10-bit and general call headers never match here
              d.sdaLow = 1'b1;
              d.rdDir = q.shift[0];
              d.addressed = 1'b1;
            end
            else
            begin
              d.phase = SLV_IGNORE;
            end
          end
          else if (sclFall && q.bitCnt == DATA_BITS)
          begin
            // write byte: acknowledge and file it
            d.sdaLow = 1'b1;
            if (q.byteIdx == BYTE_CTRL)
            begin
              d.ctrl = q.shift;
              d.byteIdx = BYTE_MSB;
            end
            else if (q.byteIdx == BYTE_MSB)
            begin
              d.msb = q.shift;
              d.byteIdx = BYTE_LSB;
            end
            else
            begin
              // pairs of msb/lsb repeat without a new control byte
              d.wordPend = 1'b1;
              d.byteIdx = BYTE_MSB;
            end
          end
          else if (sclFall && q.bitCnt == ACK_SLOT)
          begin
            d.sdaLow = 1'b0;
            d.bitCnt = '0;
            if (q.wordPend)
            begin
              // word lands on the fall of the acknowledge clock
              d.word = {q.msb, q.shift};
              d.wordStb = 1'b1;
              d.wordPend = 1'b0;
            end
            if (q.phase == SLV_ADDR && q.rdDir)
            begin
              // readback starts with the high byte
              d.phase = SLV_READ;
              d.shift = readWord[15:8];
              d.sdaLow = !readWord[15];
              d.byteIdx = 2'h1;
            end
            else if (q.phase == SLV_ADDR)
            begin
              d.phase = SLV_WRITE;
            end
          end
        end
        SLV_READ:
        begin
          if (sclRise && q.bitCnt < DATA_BITS)
          begin
            d.bitCnt = q.bitCnt + 4'h1;
          end
          else if (sclRise && q.bitCnt == DATA_BITS)
          begin
            // master is the receiver and acknowledges
            d.nak = d.sdaF;
            d.bitCnt = ACK_SLOT;
          end
          else if (sclFall && q.bitCnt != '0 && q.bitCnt < DATA_BITS)
          begin
            // next bit changes only while the clock is low
            d.shift = {q.shift[6:0], 1'b0};
            d.sdaLow = !q.shift[6];
          end
          else if (sclFall && q.bitCnt == DATA_BITS)
          begin
            d.sdaLow = 1'b0;
          end
          else if (sclFall && q.bitCnt == ACK_SLOT)
          begin
            d.bitCnt = '0;
            if (!q.nak)
            begin
              d.shift = nextRd;
              d.sdaLow = !nextRd[7];
              d.byteIdx = {1'b0, !q.byteIdx[0]};
            end
            else
            begin
              // not acknowledged: stay off the line until a start
              d.phase = SLV_IGNORE;
            end
          end
        end
        default:
        begin
          // idle or ignoring: only start and stop matter
          d.sdaLow = 1'b0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      q <= SLV_RESET;
    end
    else
    begin
      q <= d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs; the slave never drives scl
  assign link.sdaSlvOut = 1'b0;
  assign link.sdaSlvOe = q.sdaLow;
  assign ctrlByte = q.ctrl;
  assign dataWord = q.word;
  assign wordStrobe = q.wordStb;
  assign hsMode = q.hsMode;
  assign addressed = q.addressed;

endmodule

// [rtl/qdis_sync.sv]
`timescale 1ns/10ps
module qdis_sync #(
  parameter int WIDTH = 2,
  parameter logic RST_VAL = 1'b1
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // levels from outside the clock domain
  input wire logic [WIDTH-1:0] asyncIn,
  // levels safe to use
  output logic [WIDTH-1:0] syncOut
);

  ////////////////////////////////////////////////////////////////////////////
  // two flops per bit; the first stage feeds only the second
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++)
    begin : g_bit
      logic meta_q; // metastable stage
      logic stable_q; // settled stage
      always_ff @(posedge sys_clk)
      begin
        if (rst)
        begin
          meta_q <= RST_VAL;
          stable_q <= RST_VAL;
        end
        else
        begin
          meta_q <= asyncIn[i];
          stable_q <= meta_q;
        end
      end
      assign syncOut[i] = stable_q;
    end
  endgenerate

endmodule

// [tb/qdis_link_checker.sv]
`timescale 1ns/10ps
module qdis_link_checker (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // open-drain drivers
  input wire logic sclOut,
  input wire logic sclOe,
  input wire logic sdaMstOut,
  input wire logic sdaMstOe,
  input wire logic sdaSlvOut,
  input wire logic sdaSlvOe,
  // resolved lines
  input wire logic sclLine,
  input wire logic sdaLine
);
  import qdis_pkg::*;
  ////////////////////////////////////////////////////////////////////////////
  // wire tracker: bit position within the current byte
  typedef struct packed {
    logic sclPrev; // line levels one cycle ago
    logic sdaPrev;
    logic [3:0] bitCnt; // rising clocks in this byte, 9 at ack
    logic first; // still in the address byte
    logic wrAck; // slave took a write, so data bytes need acks
    logic [7:0] shift; // bits seen on rising clock
  } qdis_chk_state_type;
  qdis_chk_state_type chkQ;
  qdis_chk_state_type chkD;
  logic startSeen;
  logic stopSeen;
  logic sclRise;
  logic foreign; // first byte with upper bits other than 10011 that is also not a broadcast write
  assign startSeen = chkQ.sclPrev && sclLine && chkQ.sdaPrev && !sdaLine;
  assign stopSeen = chkQ.sclPrev && sclLine && !chkQ.sdaPrev && sdaLine;
  assign sclRise = sclLine && !chkQ.sclPrev;
  assign foreign = (chkQ.shift[7:3] != ADDR_PREFIX) && (chkQ.shift != {BCAST_ADDR, 1'h0});
  // next tracker state
  always_comb
  begin
    chkD = chkQ;
    chkD.sclPrev = sclLine;
    chkD.sdaPrev = sdaLine;
    if (startSeen)
    begin
      chkD.bitCnt = 4'h0;
      chkD.first = 1'h1;
    end
    else if (stopSeen)
      chkD.wrAck = 1'h0;
    else if (sclRise)
    begin
      chkD.shift = {chkQ.shift[6:0], sdaLine};
      chkD.bitCnt = (chkQ.bitCnt == 4'h9) ? 4'h1 : chkQ.bitCnt + 4'h1;
      if (chkQ.bitCnt == 4'h9)
        chkD.first = 1'h0;
      if (chkQ.first && chkQ.bitCnt == 4'h8)
        chkD.wrAck = sdaSlvOe && !chkQ.shift[0];
    end
  end
  // lines idle high out of reset
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      chkQ <= '{sclPrev: 1'h1, sdaPrev: 1'h1, default: '0};
    else
      chkQ <= chkD;
  end
  ////////////////////////////////////////////////////////////////////////////
  // properties
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  sequence s_first_ninth;
    sclRise && chkQ.first && chkQ.bitCnt == 4'h8;
  endsequence
  sequence s_data_eighth_fall;
    !sclLine && chkQ.sclPrev && !chkQ.first && chkQ.wrAck && chkQ.bitCnt == 4'h8;
  endsequence
  property p_start_master;
    startSeen |-> sdaMstOe;
  endproperty
  property p_slave_steady;
    sclLine && chkQ.sclPrev |-> $stable(sdaSlvOe);
  endproperty
  property p_stop_release;
    stopSeen |-> !sdaSlvOe [*8];
  endproperty
  property p_scl_high_min;
    $rose(sclLine) |-> sclLine [*8];
  endproperty
  property p_addr_quiet;
    sclRise && chkQ.first && chkQ.bitCnt < 4'h8 |-> !sdaSlvOe;
  endproperty
  property p_ack_slot_free;
    s_first_ninth |-> !sdaMstOe;
  endproperty
  property p_no_foreign_ack;
    s_first_ninth ##0 foreign |-> !sdaSlvOe;
  endproperty
  property p_ack_writes;
    sclRise && !chkQ.first && chkQ.bitCnt == 4'h8 && chkQ.wrAck |-> sdaSlvOe;
  endproperty
  property p_ack_timely;
    s_data_eighth_fall |-> ##[1:20] sdaSlvOe;
  endproperty
  // drivers only ever pull low; the clock line follows the master's enable
  property p_open_drain;
    !sclOut && !sdaMstOut && !sdaSlvOut && (sclOe != sclLine);
  endproperty
  a_start_master: assert property (p_start_master) else $error("start not made by master");
  a_slave_steady: assert property (p_slave_steady) else $error("slave data moved with clock high");
  a_stop_release: assert property (p_stop_release) else $error("slave holds data after stop");
  a_scl_high_min: assert property (p_scl_high_min) else $error("clock high phase too short");
  a_addr_quiet: assert property (p_addr_quiet) else $error("slave drove during address bits");
  a_ack_slot_free: assert property (p_ack_slot_free) else $error("master holds ack slot");
  a_no_foreign_ack: assert property (p_no_foreign_ack) else $error("foreign address acked");
  a_ack_writes: assert property (p_ack_writes) else $error("write byte not acked");
  a_ack_timely: assert property (p_ack_timely) else $error("ack came late");
  a_open_drain: assert property (p_open_drain) else $error("line driven high or clock not from master");
endmodule

// [tb/quad_dac_i2c_slave_front_end_tb.sv]
`timescale 1ns/10ps
`define CHK(nm, exp, got) begin numChecks++; if ((got) !== (exp)) begin errCount++; \
  $display("[FAIL] %s expected %h seen %h", nm, exp, got); end end
module quad_dac_i2c_slave_front_end_tb;
  import qdis_pkg::*;
  localparam int LIM = 8000; // byte is 36 quarters of 125 cycles
  // clock, reset, master port
  logic sys_clk;
  logic rst;
  logic cmdValid;
  logic cmdReady;
  qdis_cmd_type cmdKind;
  logic [7:0] cmdData;
  logic cmdAck;
  logic rspValid;
  logic [7:0] rspData;
  logic rspAck;
  logic hsRate;
  // slave side
  logic [15:0] readWord;
  logic [7:0] ctrlByte;
  logic [15:0] dataWord;
  logic wordStrobe;
  logic hsMode;
  logic addressed;
  int errCount = 0;
  int numChecks = 0;
  int strobeCnt = 0;
  ////////////////////////////////////////////////////////////////////////////
  // the two ends and the wire checker
  qdis_link_if link();
  qdis_master qdis_master_inst (.sys_clk(sys_clk), .rst(rst), .link(link), .cmdValid(cmdValid),
    .cmdReady(cmdReady), .cmdKind(cmdKind), .cmdData(cmdData), .cmdAck(cmdAck), .rspValid(rspValid),
    .rspData(rspData), .rspAck(rspAck), .hsRate(hsRate));
  // straps give own address 1001101
  qdis_slave qdis_slave_inst (.sys_clk(sys_clk), .rst(rst), .link(link), .addr_select_bit_low(1'h1),
    .addr_select_bit_high(1'h0), .readWord(readWord), .ctrlByte(ctrlByte), .dataWord(dataWord),
    .wordStrobe(wordStrobe), .hsMode(hsMode), .addressed(addressed));
  qdis_link_checker qdis_link_checker_inst (.sys_clk(sys_clk), .rst(rst), .sclOut(link.sclOut),
    .sclOe(link.sclOe), .sdaMstOut(link.sdaMstOut), .sdaMstOe(link.sdaMstOe), .sdaSlvOut(link.sdaSlvOut),
    .sdaSlvOe(link.sdaSlvOe), .sclLine(link.sclLine), .sdaLine(link.sdaLine));
  // 200 MHz
  initial
  begin
    sys_clk = 1'h0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  // strobes counted mid-cycle, away from the edge
  always @(negedge sys_clk)
    if (wordStrobe === 1'h1)
      strobeCnt++;
  ////////////////////////////////////////////////////////////////////////////
  // verdict
  task automatic endSim;
    $display("checks %0d errors %0d", numChecks, errCount);
    if (errCount == 0 && numChecks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // one master command; valid held until taken, then a settle for the slave's filter lag
  task automatic doCmd(input qdis_cmd_type k, input logic [7:0] d, input logic a);
    int n;
    n = 0;
    @(negedge sys_clk);
    cmdKind = k;
    cmdData = d;
    cmdAck = a;
    cmdValid = 1'h1;
    while (cmdReady !== 1'h1 && n < LIM)
    begin
      @(negedge sys_clk);
      n++;
    end
    @(negedge sys_clk);
    cmdValid = 1'h0;
    while (rspValid !== 1'h1 && n < LIM)
    begin
      @(negedge sys_clk);
      n++;
    end
    if (n >= LIM)
    begin
      errCount++;
      $display("[FAIL] rspValid expected 1 seen 0");
      endSim();
    end
    repeat (32) @(negedge sys_clk);
  endtask
  task automatic wr(input logic [7:0] d, input logic expAck);
    doCmd(CMD_WRITE, d, 1'h0);
    `CHK("rspAck", expAck, rspAck)
  endtask
  task automatic word(input logic [15:0] w, input int n);
    `CHK("strobes", n, strobeCnt)
    `CHK("dataWord", w, dataWord)
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    rst = 1'h1;
    cmdValid = 1'h0;
    cmdKind = CMD_START;
    cmdData = 8'h00;
    cmdAck = 1'h0;
    readWord = 16'h5aa5;
    repeat (4) @(negedge sys_clk);
    rst = 1'h0;
    repeat (4) @(negedge sys_clk);
    // fast write, then a lone msb that must be dropped
    doCmd(CMD_START, 8'h00, 1'h0);
    wr(8'h9a, 1'h1);
    `CHK("addressed", 1'h1, addressed)
    wr(8'h10, 1'h1);
    wr(8'h80, 1'h1);
    wr(8'h01, 1'h1);
    `CHK("ctrlByte", 8'h10, ctrlByte)
    word(16'h8001, 1);
    wr(8'h12, 1'h1);
    doCmd(CMD_STOP, 8'h00, 1'h0);
    word(16'h8001, 1);
    `CHK("addressed", 1'h0, addressed)
    // other device's address: nothing acked afterwards
    doCmd(CMD_START, 8'h00, 1'h0);
    wr(8'h98, 1'h0);
    wr(8'h55, 1'h0);
    `CHK("addressed", 1'h0, addressed)
    // general call, 10-bit prefix, broadcast read, then broadcast write
    doCmd(CMD_START, 8'h00, 1'h0);
    wr(8'h00, 1'h0);
    doCmd(CMD_START, 8'h00, 1'h0);
    wr(8'hf0, 1'h0);
    doCmd(CMD_START, 8'h00, 1'h0);
    wr(8'h91, 1'h0);
    doCmd(CMD_START, 8'h00, 1'h0);
    wr(8'h90, 1'h1);
    wr(8'h20, 1'h1);
    `CHK("ctrlByte", 8'h20, ctrlByte)
    doCmd(CMD_STOP, 8'h00, 1'h0);
    // high-speed entry, full-scale and zero codes, kept across a repeated start
    doCmd(CMD_START, 8'h00, 1'h0);
    doCmd(CMD_HSCODE, HS_MASTER_CODE, 1'h0);
    `CHK("rspAck", 1'h0, rspAck)
    `CHK("hsMode", 1'h1, hsMode)
    `CHK("hsRate", 1'h1, hsRate)
    doCmd(CMD_START, 8'h00, 1'h0);
    wr(8'h9a, 1'h1);
    wr(8'h10, 1'h1);
    wr(8'hff, 1'h1);
    wr(8'hff, 1'h1);
    word(16'hffff, 2);
    wr(8'h00, 1'h1);
    wr(8'h00, 1'h1);
    word(16'h0000, 3);
    doCmd(CMD_START, 8'h00, 1'h0);
    `CHK("hsMode", 1'h1, hsMode)
    wr(8'h9a, 1'h1);
    doCmd(CMD_STOP, 8'h00, 1'h0);
    `CHK("hsMode", 1'h0, hsMode)
    `CHK("hsRate", 1'h0, hsRate)
    // readback: master acks the high byte, refuses the low one
    doCmd(CMD_START, 8'h00, 1'h0);
    wr(8'h9b, 1'h1);
    doCmd(CMD_READ, 8'h00, 1'h1);
    `CHK("rspData", 8'h5a, rspData)
    doCmd(CMD_READ, 8'h00, 1'h0);
    `CHK("rspData", 8'ha5, rspData)
    doCmd(CMD_STOP, 8'h00, 1'h0);
    endSim();
  end
endmodule
